// ===== sim/agdr_fet_model.sv
// Switch-node model of the external half-bridge seen by the gate control
`timescale 1ns/1ns
`default_nettype none
module agdr_fet_model #(
  parameter int DLY = 12
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Gate drive from the block; low-side select from the bench
  input wire logic hs_gate_on_i,
  input wire logic ls_gate_on_i,
  input wire logic gate_sink_i,
  input wire logic lside_i,
  // Comparator outputs
  output logic vsh_above_hi_o,
  output logic vsh_below_lo_o
);
  logic [DLY-1:0] node_r;
  logic drv;
  // Gate charging pulls the node toward the PWM side, else it free-wheels
  assign drv = (hs_gate_on_i | ls_gate_on_i) & ~gate_sink_i;
  // Node lags the drive by a fixed delay
  always_ff @(posedge mclk_i or negedge arst_n_i)
    if (!arst_n_i) node_r <= '0;
    else node_r <= {node_r[DLY-2:0], lside_i ^ drv};
  assign vsh_above_hi_o = node_r[DLY-1];
  assign vsh_below_lo_o = ~node_r[DLY-1];
endmodule : agdr_fet_model
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the gate delay regulation block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} agdr_row_t;
  logic clk, rst_n, wr, rd, pwm, hi, lo, hs, ls, snk, flg, lsd;
  logic [7:0] adr;
  logic [31:0] wd, rdat, s, t;
  logic [5:0] cur, c0, ck, cf;
  logic [1:0] sd;
  int err_count, num_checks;
  agdr_row_t rows [11];
  agdr_gate_ctrl #(.BD_DIV(1)) agdr_gate_ctrl_i (.mclk_i(clk), .arst_n_i(rst_n), .addr_i(adr), .wdata_i(wd),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .pwm_i(pwm), .vsh_above_hi_i(hi), .vsh_below_lo_i(lo),
    .hs_gate_on_o(hs), .ls_gate_on_o(ls), .gate_cur_o(cur), .gate_sink_o(snk), .delay_regulation_flag_o(flg));
  agdr_fet_model agdr_fet_model_i (.mclk_i(clk), .arst_n_i(rst_n), .hs_gate_on_i(hs), .ls_gate_on_i(ls),
    .gate_sink_i(snk), .lside_i(lsd), .vsh_above_hi_o(hi), .vsh_below_lo_o(lo));
  // Compare one result word
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Register bus cycles
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {wr, adr, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) {rd, adr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) d = rdat;
  endtask : rreg
  // One PWM period, capturing codes at turn-on, k cycles later and turn-off
  task automatic cyc(input int k);
    int n;
    @(posedge clk) pwm <= 1'b1;
    for (n = 0; n < 60 && hs !== 1'b1 && ls !== 1'b1; n++) @(negedge clk);
    c0 = cur;
    sd = {hs, ls};
    repeat (k) @(negedge clk);
    ck = cur;
    repeat (40) @(negedge clk);
    @(posedge clk) pwm <= 1'b0;
    for (n = 0; n < 60 && snk !== 1'b1; n++) @(negedge clk);
    cf = cur;
    repeat (60) @(negedge clk);
  endtask : cyc
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog
  initial
  begin
    #3_000_000;
    err_count++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    {rst_n, wr, rd, pwm, lsd, adr, wd} = '0;
    err_count = 0;
    num_checks = 0;
    rows = '{'{0, 8'h00, 0, 0}, '{0, 8'h04, 0, 0}, '{0, 8'h08, 0, 32'h003F_0000}, '{0, 8'h0C, 0, 0},
      '{0, 8'h10, 0, 0}, '{0, 8'h14, 0, 0}, '{0, 8'h18, 0, 0}, '{1, 8'h04, '1, 32'h0000_FFFF},
      '{1, 8'h08, '1, 32'h3F3F_3F3F}, '{1, 8'h0C, '1, 32'h0000_FFFF}, '{1, 8'h10, '1, 0}};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].w) wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, s);
      chk(s, rows[i].e);
    end
    done("registers");
    wreg(8'h08, 32'h050F_0C0A);
    wreg(8'h0C, 32'h0000_0808);
    wreg(8'h04, 32'h0000_0000);
    wreg(8'h00, 32'h0000_0022);
    rreg(8'h14, s);
    chk(s, 32'h0000_0C0A);
    cyc(5);
    chk(32'({c0, ck}), 32'h0000_028A);
    rreg(8'h14, s);
    chk(s, 32'h0000_0D0B);
    wreg(8'h00, 32'h0000_002E);
    cyc(6);
    chk(32'({c0, ck}), 32'h0000_02C5);
    rreg(8'h14, s);
    chk(32'(s[5:0]), 32'h0000_000D);
    done("adaptation");
    rreg(8'h10, t);
    wreg(8'h04, 32'(t[15:0]));
    repeat (7) cyc(0);
    chk(32'(flg), 32'h0000_0000);
    cyc(0);
    chk(32'(flg), 32'h0000_0001);
    rreg(8'h14, s);
    chk(32'(s[23:16]), 32'h0000_0088);
    for (int i = 0; i < 4; i++)
    begin
      wreg(8'h04, i[0] ? 32'h0000_1010 : 32'h0000_1212);
      cyc(0);
    end
    chk(32'(flg), 32'h0000_0001);
    rreg(8'h14, s);
    chk(32'(s[27:16]), 32'h0000_0F44);
    done("regulation");
    wreg(8'h00, 32'h0000_0021);
    rreg(8'h10, s);
    chk(32'({flg, s[16]}), 32'h0000_0000);
    cyc(0);
    chk(32'({c0, cf}), 32'h0000_028C);
    rreg(8'h10, s);
    chk(s, 32'(t[15:0]));
    wreg(8'h00, 32'h0000_0020);
    cyc(0);
    chk(32'(c0), 32'h0000_0005);
    lsd <= 1'b1;
    wreg(8'h00, 32'h0000_0031);
    repeat (20) @(posedge clk);
    cyc(0);
    chk(32'({sd, c0}), 32'h0000_004A);
    rreg(8'h10, s);
    chk(s, 32'(t[15:0]));
    done("modes");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

// ===== src/agdr_cur_adapt.sv
// Adaptive pre-phase gate current code
`timescale 1ns/1ns
`default_nettype none
module agdr_cur_adapt (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic load_i,
  input wire logic upd_i,
  input wire logic two_i,
  // Limits and measurement
  input wire logic [5:0] init_i,
  input wire logic [5:0] max_i,
  input wire logic [7:0] meas_i,
  input wire logic [7:0] tgt_i,
  // Adapted code
  output logic [5:0] code_o
);

  // Load on enable, then step toward the target delay
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) code_o <= agdr_pkg::ADAPT_RST;
    else if (load_i) code_o <= agdr_pkg::min_code(init_i, max_i); // RULE_14
    else if (upd_i && (meas_i == tgt_i)) code_o <= agdr_pkg::min_code(code_o, max_i); // RULE_13
    else if (upd_i) code_o <= agdr_pkg::step_code(code_o, meas_i > tgt_i, two_i, max_i); // RULE_15
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_init_load: assert property (load_i |=> code_o == agdr_pkg::min_code($past(init_i), $past(max_i))) // RULE_14
    else $error("adaptive code not loaded with smaller code");
  a_step_two: assert property (upd_i && !load_i && two_i && meas_i > tgt_i
                               && ({1'b0, code_o} + 7'h02 <= {1'b0, max_i})
                               |=> code_o == $past(code_o) + 6'h02) // RULE_15
    else $error("adaptive code did not take two steps");
  a_code_bound: assert property (upd_i && !load_i |=> code_o <= $past(max_i)) // RULE_13
    else $error("adaptive code above limit");

endmodule : agdr_cur_adapt
`default_nettype wire

// ===== src/agdr_gate_ctrl.sv
// PWM half-bridge gate sequencing with adaptive delay regulation
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// (RULE_01) Low-side PWM runs the same sequence, gates and thresholds swapped.
// (RULE_02) One regulation flag per bridge, valid in the two adaptive modes.
// (RULE_03) In regulation when both match counters have reached eight or more.
// (RULE_04) Each PWM cycle a counter goes up on match, down on mismatch.
// (RULE_05) Also in regulation after three consecutive error sign reversals.
// (RULE_06) Without time modulation one current covers each whole pre-phase.
// (RULE_07) With time modulation each pre-phase splits into two current steps; mode one keeps its single fixed code instead.
// (RULE_08) Non-adaptive modes stop regulating the delays.
// (RULE_09) Non-adaptive modes still measure and report both delays.
// (RULE_10) Mode zero skips the pre-charge and pre-discharge phases.
// (RULE_11) Mode one pre-charges with the fixed initial pre-charge code.
// (RULE_12) Mode one pre-discharges with the fixed initial pre-discharge code.
// (RULE_13) Current code is six bits, 64 ascending steps, 0.5 mA to 100 mA.
// (RULE_14) Setting PWM enable loads the smaller of initial and maximum code.
// (RULE_15) Adaptation moves one step, or two when step size is set.
// (RULE_16) Match counters saturate and clear when regulation restarts.
module agdr_gate_ctrl #(
  parameter int BD_DIV = agdr_pkg::BD_DIV
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // PWM input and switch-node comparators
  input wire logic pwm_i,
  input wire logic vsh_above_hi_i,
  input wire logic vsh_below_lo_i,
  // Gate driver control
  output logic hs_gate_on_o,
  output logic ls_gate_on_o,
  output logic [5:0] gate_cur_o,
  output logic gate_sink_o,
  output logic delay_regulation_flag_o
);

  typedef enum logic [2:0] {ST_OFF, ST_PRE_ON, ST_CHG, ST_ON, ST_PRE_OFF, ST_DCHG} agdr_state_t;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  agdr_state_t state_r;
  agdr_state_t state_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] tgt_r;
  logic [31:0] cur_r;
  logic [31:0] dur_r;
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] pin_f_r;
  logic [7:0] div_r;
  logic [7:0] ph_cnt_r;
  logic [7:0] dly_cnt_r;
  logic [7:0] meas_on_r;
  logic [7:0] meas_off_r;
  logic [5:0] cur_nxt;
  logic sink_nxt;
  logic [5:0] ad_pchg;
  logic [5:0] ad_pdchg;
  logic [3:0] on_cnt;
  logic [3:0] off_cnt;
  logic [1:0] on_rev;
  logic [1:0] off_rev;
  logic [1:0] mode;
  logic tmod;
  logic two;
  logic lside;
  logic pen;
  logic adaptive;
  logic no_pre;
  logic fixed;
  logic wr_ctrl;
  logic pen_set;
  logic bd_tick;
  logic pwm_eff;
  logic on_thr;
  logic off_thr;
  logic on_done;
  logic off_done;
  logic cnt_clr;

  // Conducting half of the sequence
  function automatic logic on_side(input agdr_state_t s);
    on_side = (s == ST_PRE_ON) || (s == ST_CHG) || (s == ST_ON);
  endfunction : on_side

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  assign mode = ctrl_r[agdr_pkg::CTRL_MODE +: 2];
  assign tmod = ctrl_r[agdr_pkg::CTRL_TMOD];
  assign two = ctrl_r[agdr_pkg::CTRL_STEP];
  assign lside = ctrl_r[agdr_pkg::CTRL_LSIDE];
  assign pen = ctrl_r[agdr_pkg::CTRL_PEN];
  assign adaptive = mode[1];
  assign no_pre = (mode == agdr_pkg::MODE_NO_PHASE);
  assign fixed = (mode == agdr_pkg::MODE_FIXED);
  assign wr_ctrl = wr_i && (addr_i == agdr_pkg::ADR_CTRL);
  assign pen_set = wr_ctrl && wdata_i[agdr_pkg::CTRL_PEN] && !pen; // RULE_14

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Writable configuration words
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_r <= agdr_pkg::CTRL_RST;
      tgt_r <= agdr_pkg::TGT_RST;
      cur_r <= agdr_pkg::CUR_RST;
      dur_r <= agdr_pkg::DUR_RST;
    end
    else if (wr_i)
    begin
      if (addr_i == agdr_pkg::ADR_CTRL) ctrl_r <= wdata_i & agdr_pkg::CTRL_MASK;
      if (addr_i == agdr_pkg::ADR_TGT) tgt_r <= wdata_i & agdr_pkg::TGT_MASK;
      if (addr_i == agdr_pkg::ADR_CUR) cur_r <= wdata_i & agdr_pkg::CUR_MASK;
      if (addr_i == agdr_pkg::ADR_DUR) dur_r <= wdata_i & agdr_pkg::DUR_MASK;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) rdata_o <= 32'h0000_0000;
    else if (!rd_i) rdata_o <= 32'h0000_0000;
    else
    begin
      case (addr_i)
        agdr_pkg::ADR_CTRL: rdata_o <= ctrl_r;
        agdr_pkg::ADR_TGT: rdata_o <= tgt_r;
        agdr_pkg::ADR_CUR: rdata_o <= cur_r;
        agdr_pkg::ADR_DUR: rdata_o <= dur_r;
        agdr_pkg::ADR_STAT: rdata_o <= {15'h0000, delay_regulation_flag_o, meas_off_r, meas_on_r}; // RULE_09
        agdr_pkg::ADR_ADAPT: rdata_o <= {4'h0, off_rev, on_rev, off_cnt, on_cnt, 2'h0, ad_pdchg, 2'h0, ad_pchg};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and bridge clock
  // ----------------------------------------------------------------
  // Three stages; accept a change once stages two and three agree
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      pin_f_r <= 3'h0;
    end
    else
    begin
      s1_r <= {vsh_below_lo_i, vsh_above_hi_i, pwm_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_f_r <= (s2_r & s3_r) | (pin_f_r & (s2_r ^ s3_r));
    end
  end

  // Bridge driver clock enable
  assign bd_tick = (div_r == 8'(BD_DIV - 1));

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) div_r <= 8'h00;
    else div_r <= bd_tick ? 8'h00 : div_r + 8'h01;
  end

  assign pwm_eff = pen && pin_f_r[0];
  assign on_thr = lside ? pin_f_r[2] : pin_f_r[1]; // RULE_01
  assign off_thr = lside ? pin_f_r[1] : pin_f_r[2]; // RULE_01

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  // Next phase from PWM level, timers and switch-node thresholds
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF: if (pwm_eff) state_nxt = no_pre ? ST_CHG : ST_PRE_ON; // RULE_10
      ST_PRE_ON:
      begin
        if (!pwm_eff) state_nxt = no_pre ? ST_DCHG : ST_PRE_OFF;
        else if (ph_cnt_r >= dur_r[agdr_pkg::F_LO +: 8]) state_nxt = ST_CHG;
      end
      ST_CHG:
      begin
        if (on_thr) state_nxt = ST_ON;
        else if (!pwm_eff) state_nxt = no_pre ? ST_DCHG : ST_PRE_OFF; // RULE_10
      end
      ST_ON: if (!pwm_eff) state_nxt = no_pre ? ST_DCHG : ST_PRE_OFF; // RULE_10
      ST_PRE_OFF: if (ph_cnt_r >= dur_r[agdr_pkg::F_HI +: 8]) state_nxt = ST_DCHG;
      ST_DCHG: if (off_thr || pwm_eff) state_nxt = ST_OFF;
      default: state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) state_r <= ST_OFF;
    else state_r <= state_nxt;
  end

  // Phase timer in bridge clock ticks
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) ph_cnt_r <= 8'h00;
    else if (state_nxt != state_r) ph_cnt_r <= 8'h00;
    else if (bd_tick && (ph_cnt_r != 8'hFF)) ph_cnt_r <= ph_cnt_r + 8'h01;
  end

  // Delay counter from the PWM edge to the threshold crossing
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) dly_cnt_r <= 8'h00;
    else if (on_side(state_nxt) != on_side(state_r)) dly_cnt_r <= 8'h00;
    else if (bd_tick && (dly_cnt_r != 8'hFF)) dly_cnt_r <= dly_cnt_r + 8'h01;
  end

  // ----------------------------------------------------------------
  // Delay measurement and regulation
  // ----------------------------------------------------------------
  assign on_done = (state_r == ST_CHG) && on_thr;
  assign off_done = (state_r == ST_DCHG) && off_thr;
  assign cnt_clr = pen_set || !adaptive || !pen; // RULE_16

  // Measured delays kept in every mode
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meas_on_r <= 8'h00;
      meas_off_r <= 8'h00;
    end
    else
    begin
      if (on_done) meas_on_r <= dly_cnt_r; // RULE_09
      if (off_done) meas_off_r <= dly_cnt_r; // RULE_09
    end
  end

  agdr_cur_adapt u_pchg (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .load_i(pen_set),
    .upd_i(on_done && adaptive), // RULE_08
    .two_i(two),
    .init_i(cur_r[agdr_pkg::F_LO +: 6]),
    .max_i(cur_r[agdr_pkg::CUR_MAXF +: 6]),
    .meas_i(dly_cnt_r),
    .tgt_i(tgt_r[agdr_pkg::F_LO +: 8]),
    .code_o(ad_pchg)
  );

  agdr_cur_adapt u_pdchg (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .load_i(pen_set),
    .upd_i(off_done && adaptive), // RULE_08
    .two_i(two),
    .init_i(cur_r[agdr_pkg::F_HI +: 6]),
    .max_i(cur_r[agdr_pkg::CUR_MAXF +: 6]),
    .meas_i(dly_cnt_r),
    .tgt_i(tgt_r[agdr_pkg::F_HI +: 8]),
    .code_o(ad_pdchg)
  );

  // Counters step once per PWM cycle, at the end of turn-off
  agdr_match_cnt u_on_cnt (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .clear_i(cnt_clr),
    .upd_i(off_done && adaptive), // RULE_04
    .meas_i(meas_on_r),
    .tgt_i(tgt_r[agdr_pkg::F_LO +: 8]),
    .cnt_o(on_cnt),
    .rev_o(on_rev)
  );

  agdr_match_cnt u_off_cnt (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .clear_i(cnt_clr),
    .upd_i(off_done && adaptive), // RULE_04
    .meas_i(dly_cnt_r),
    .tgt_i(tgt_r[agdr_pkg::F_HI +: 8]),
    .cnt_o(off_cnt),
    .rev_o(off_rev)
  );

  // Regulation flag
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) delay_regulation_flag_o <= 1'b0;
    else delay_regulation_flag_o <= adaptive // RULE_02
      && (((on_cnt >= agdr_pkg::REG_THRESH) && (off_cnt >= agdr_pkg::REG_THRESH)) // RULE_03
      || ((on_rev >= agdr_pkg::REV_THRESH) && (off_rev >= agdr_pkg::REV_THRESH))); // RULE_05
  end

  // ----------------------------------------------------------------
  // Gate outputs
  // ----------------------------------------------------------------
  // Current code and direction per phase
  always_comb
  begin
    cur_nxt = cur_r[agdr_pkg::CUR_MAXF +: 6];
    sink_nxt = 1'b1;
    unique case (state_r)
      ST_PRE_ON:
      begin
        sink_nxt = 1'b0;
        if (fixed) cur_nxt = cur_r[agdr_pkg::F_LO +: 6]; // RULE_11
        else if (tmod && (ph_cnt_r >= (dur_r[agdr_pkg::F_LO +: 8] >> 1))) cur_nxt = cur_r[agdr_pkg::CUR_CHG +: 6]; // RULE_07
        else cur_nxt = ad_pchg; // RULE_06
      end
      ST_CHG:
      begin
        sink_nxt = 1'b0;
        cur_nxt = cur_r[agdr_pkg::CUR_CHG +: 6]; // RULE_13
      end
      ST_ON: sink_nxt = 1'b0;
      ST_PRE_OFF:
      begin
        if (fixed) cur_nxt = cur_r[agdr_pkg::F_HI +: 6]; // RULE_12
        else if (tmod && (ph_cnt_r >= (dur_r[agdr_pkg::F_HI +: 8] >> 1))) cur_nxt = cur_r[agdr_pkg::CUR_CHG +: 6]; // RULE_07
        else cur_nxt = ad_pdchg; // RULE_06
      end
      ST_DCHG: cur_nxt = cur_r[agdr_pkg::CUR_CHG +: 6];
      default: sink_nxt = 1'b1;
    endcase
  end

  // Registered gate controls; complementary gate stays off
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hs_gate_on_o <= 1'b0;
      ls_gate_on_o <= 1'b0;
      gate_cur_o <= agdr_pkg::CUR_MIN;
      gate_sink_o <= 1'b1;
    end
    else
    begin
      hs_gate_on_o <= on_side(state_r) && !lside; // RULE_01
      ls_gate_on_o <= on_side(state_r) && lside; // RULE_01
      gate_cur_o <= cur_nxt;
      gate_sink_o <= sink_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_on_done;
    state_r == ST_CHG && on_thr;
  endsequence

  sequence s_mode0_rise;
    state_r == ST_OFF && pwm_eff && no_pre;
  endsequence

  a_lowside_swap: assert property (state_r == ST_ON && lside ##1 lside |-> ls_gate_on_o && !hs_gate_on_o) // RULE_01
    else $error("low-side mapping not swapped");
  a_flag_mode: assert property (!adaptive |=> !delay_regulation_flag_o) // RULE_02
    else $error("regulation flag set outside adaptive mode");
  a_flag_count: assert property (adaptive && on_cnt >= 4'h8 && off_cnt >= 4'h8 |=> delay_regulation_flag_o) // RULE_03
    else $error("regulation flag missing with both counters at eight");
  a_rev_flag: assert property (adaptive && on_rev >= 2'h3 && off_rev >= 2'h3 |=> delay_regulation_flag_o) // RULE_05
    else $error("regulation flag missing after three reversals");
  a_single_cur: assert property (state_r == ST_PRE_ON && adaptive && !tmod |=> gate_cur_o == $past(ad_pchg)) // RULE_06
    else $error("pre-charge current not the adaptive code");
  a_split_cur: assert property (state_r == ST_PRE_ON && adaptive && tmod && ph_cnt_r >= (dur_r[7:0] >> 1)
                                |=> gate_cur_o == $past(cur_r[29:24])) // RULE_07
    else $error("second pre-charge sub-interval current wrong");
  a_no_adapt: assert property (!adaptive && !pen_set |=> $stable(ad_pchg) && $stable(ad_pdchg)) // RULE_08
    else $error("current adapted in non-adaptive mode");
  a_meas_kept: assert property (s_on_done |=> meas_on_r == $past(dly_cnt_r)) // RULE_09
    else $error("turn-on delay not recorded");
  a_skip_pre: assert property (s_mode0_rise |=> state_r == ST_CHG ##1 state_r != ST_PRE_ON) // RULE_10
    else $error("pre-charge not skipped in mode zero");
  a_fixed_pchg: assert property (state_r == ST_PRE_ON && fixed |=> gate_cur_o == $past(cur_r[5:0]) && !gate_sink_o) // RULE_11
    else $error("fixed pre-charge current wrong");
  a_fixed_pdchg: assert property (state_r == ST_PRE_OFF && fixed |=> gate_cur_o == $past(cur_r[13:8]) && gate_sink_o) // RULE_12
    else $error("fixed pre-discharge current wrong");

endmodule : agdr_gate_ctrl
`default_nettype wire

// ===== src/agdr_match_cnt.sv
// Delay match counter and error sign reversal tracker
`timescale 1ns/1ns
`default_nettype none
module agdr_match_cnt (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic clear_i,
  input wire logic upd_i,
  // Measured and target delay
  input wire logic [7:0] meas_i,
  input wire logic [7:0] tgt_i,
  // Results
  output logic [3:0] cnt_o,
  output logic [1:0] rev_o
);

  logic eq;
  logic gt;
  logic sign_r;
  logic vld_r;

  assign eq = (meas_i == tgt_i);
  assign gt = (meas_i > tgt_i);

  // Saturating match counter, once per PWM cycle
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) cnt_o <= 4'h0;
    else if (clear_i) cnt_o <= 4'h0; // RULE_16
    else if (upd_i && eq && (cnt_o != agdr_pkg::CNT_MAX)) cnt_o <= cnt_o + 4'h1; // RULE_04
    else if (upd_i && !eq && (cnt_o != 4'h0)) cnt_o <= cnt_o - 4'h1; // RULE_04
  end

  // Consecutive sign reversals of the delay error
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sign_r <= 1'b0;
      vld_r <= 1'b0;
      rev_o <= 2'h0;
    end
    else if (clear_i || (upd_i && eq))
    begin
      vld_r <= 1'b0;
      rev_o <= 2'h0;
    end
    else if (upd_i)
    begin
      sign_r <= gt;
      vld_r <= 1'b1;
      if (vld_r && (gt != sign_r)) rev_o <= (rev_o == agdr_pkg::REV_MAX) ? rev_o : rev_o + 2'h1; // RULE_05
      else rev_o <= 2'h0;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_cnt_inc: assert property (upd_i && !clear_i && eq && cnt_o < agdr_pkg::CNT_MAX |=> cnt_o == $past(cnt_o) + 4'h1) // RULE_04
    else $error("match counter did not count up");
  a_cnt_clear: assert property (clear_i |=> cnt_o == 4'h0 && rev_o == 2'h0) // RULE_16
    else $error("match counter not cleared");
  a_cnt_floor: assert property (upd_i && !clear_i && !eq && cnt_o == 4'h0 |=> cnt_o == 4'h0) // RULE_16
    else $error("match counter wrapped below zero");

endmodule : agdr_match_cnt
`default_nettype wire

// ===== src/agdr_pkg.sv
// Shared constants and helpers for adaptive gate delay regulation
package agdr_pkg;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int CUR_W = 6;
  localparam int DLY_W = 8;
  localparam int CNT_W = 4;
  localparam logic [5:0] CUR_MIN = 6'h00;
  localparam logic [5:0] CUR_MAX = 6'h3F;
  localparam logic [5:0] ADAPT_RST = 6'h00;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [3:0] REG_THRESH = 4'h8;
  localparam logic [1:0] REV_MAX = 2'h3;
  localparam logic [1:0] REV_THRESH = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int BD_PERIOD_NS = 200;
  localparam int BD_DIV_RAW = BD_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BD_DIV = (BD_DIV_RAW < 1) ? 1 : BD_DIV_RAW;

  // ----------------------------------------------------------------
  // Register map, field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TGT = 8'h04;
  localparam logic [7:0] ADR_CUR = 8'h08;
  localparam logic [7:0] ADR_DUR = 8'h0C;
  localparam logic [7:0] ADR_STAT = 8'h10;
  localparam logic [7:0] ADR_ADAPT = 8'h14;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_TMOD = 2;
  localparam int CTRL_STEP = 3;
  localparam int CTRL_LSIDE = 4;
  localparam int CTRL_PEN = 5;
  localparam int F_LO = 0;
  localparam int F_HI = 8;
  localparam int CUR_MAXF = 16;
  localparam int CUR_CHG = 24;
  localparam logic [31:0] CTRL_MASK = 32'h0000_003F;
  localparam logic [31:0] TGT_MASK = 32'h0000_FFFF;
  localparam logic [31:0] CUR_MASK = 32'h3F3F_3F3F;
  localparam logic [31:0] DUR_MASK = 32'h0000_FFFF;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TGT_RST = 32'h0000_0000;
  localparam logic [31:0] CUR_RST = 32'h003F_0000;
  localparam logic [31:0] DUR_RST = 32'h0000_0000;

  // Gate mode encodings
  localparam logic [1:0] MODE_NO_PHASE = 2'h0;
  localparam logic [1:0] MODE_FIXED = 2'h1;

  // Smaller of two current codes
  function automatic logic [5:0] min_code(input logic [5:0] a, input logic [5:0] b);
    min_code = (a < b) ? a : b;
  endfunction : min_code

  // One or two steps up or down, held between minimum and limit
  function automatic logic [5:0] step_code(input logic [5:0] c, input logic up,
                                           input logic two, input logic [5:0] lim);
    logic [6:0] d;
    logic [6:0] s;
    d = two ? 7'h02 : 7'h01;
    s = up ? ({1'b0, c} + d) : ({1'b0, c} - d);
    if (!up && ({1'b0, c} < d)) step_code = CUR_MIN;
    else if (s > {1'b0, lim}) step_code = lim;
    else step_code = s[5:0];
  endfunction : step_code

endpackage : agdr_pkg
